// [core/list_map_pkg.sv]
// Shared constants and types for the descriptor list map registers
package list_map_pkg;
    localparam int DESC_COUNT = 32;
    localparam int LIST_COUNT = 3;
    localparam int IDX_W = 5;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    // List numbering used by every per-list array
    localparam int LIST_ISO = 0;
    localparam int LIST_INTR = 1;
    localparam int LIST_ASYNC = 2;
    // Register offsets, element order: async, intr, iso
    localparam logic [2:0][11:0] DONE_OFF = {12'h150, 12'h140, 12'h130};
    localparam logic [2:0][11:0] SKIP_OFF = {12'h154, 12'h144, 12'h134};
    localparam logic [2:0][11:0] FINAL_OFF = {12'h158, 12'h148, 12'h138};
    localparam logic [11:0] EVENT_STATUS_OFF = 12'h160;
    localparam logic [11:0] EVENT_MASK_OFF = 12'h164;
    // Reset values
    localparam logic [31:0] SKIP_RESET = 32'hffffffff;
    localparam logic [31:0] FINAL_RESET = 32'h00000000;
    localparam logic [31:0] DONE_RESET = 32'h00000000;
    localparam logic [2:0] EVENT_STATUS_RESET = 3'h0;
    localparam logic [2:0] EVENT_MASK_RESET = 3'h0;
    typedef enum logic [0:0] {
        WALK_SCAN = 1'b0,
        WALK_OFFER = 1'b1
    } walk_state_type;
endpackage

// [core/completion_map.sv]
// Clear-on-read completion bitmap of one descriptor list
`timescale 1ns/1ns
`default_nettype none
module completion_map #(
    parameter int DEPTH = list_map_pkg::DESC_COUNT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic done_pulse,
    input wire logic [$clog2(DEPTH)-1:0] done_index,
    input wire logic clear_strobe,
    input wire logic [DEPTH-1:0] clear_mask,
    output logic [DEPTH-1:0] bits
);
    import list_map_pkg::*;
    logic [DEPTH-1:0] bits_reg;
    logic [DEPTH-1:0] set_mask;
    logic [DEPTH-1:0] keep_mask;

    always_comb begin
        set_mask = done_pulse ? ({{(DEPTH-1){1'b0}}, 1'b1} << done_index) : '0;
        // Only bits that the read returned are dropped
        keep_mask = clear_strobe ? ~clear_mask : '1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bits_reg <= DEPTH'(DONE_RESET);
        end else begin
            bits_reg <= (bits_reg & keep_mask) | set_mask;
        end
    end

    assign bits = bits_reg;
endmodule
`default_nettype wire

// [core/list_walker.sv]
// Walk pointer of one descriptor list, honouring skip and final maps
`timescale 1ns/1ns
`default_nettype none
module list_walker #(
    parameter int DEPTH = list_map_pkg::DESC_COUNT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [DEPTH-1:0] skip_bits,
    input wire logic [DEPTH-1:0] final_bits,
    input wire logic slot_ack,
    input wire logic slot_follow,
    input wire logic [$clog2(DEPTH)-1:0] slot_next_ptr,
    output logic [$clog2(DEPTH)-1:0] slot_index,
    output logic slot_request
);
    import list_map_pkg::*;
    localparam int W = $clog2(DEPTH);
    localparam logic [W-1:0] TOP = W'(DEPTH - 1);
    walk_state_type state_reg;
    walk_state_type state_next;
    logic [W-1:0] pos_reg;
    logic [W-1:0] pos_next;
    logic [W-1:0] step_pos;
    logic request_reg;

    always_comb begin
        if (final_bits[pos_reg] || pos_reg == TOP) begin
            step_pos = '0;
        end else begin
            step_pos = pos_reg + 1'b1;
        end
    end

    always_comb begin
        state_next = state_reg;
        pos_next = pos_reg;
        case (state_reg)
            WALK_SCAN: begin
                // Skipped slots are never offered, so their pointer is never seen
                if (skip_bits[pos_reg]) begin
                    pos_next = step_pos;
                end else begin
                    state_next = WALK_OFFER;
                end
            end
            WALK_OFFER: begin
                if (skip_bits[pos_reg]) begin
                    // A late skip write withdraws the offer, ack is ignored
                    state_next = WALK_SCAN;
                    pos_next = step_pos;
                end else if (slot_ack) begin
                    state_next = WALK_SCAN;
                    if (final_bits[pos_reg]) begin
                        pos_next = '0;
                    end else if (slot_follow) begin
                        pos_next = slot_next_ptr;
                    end else begin
                        pos_next = step_pos;
                    end
                end
            end
            default: begin
                state_next = WALK_SCAN;
                pos_next = '0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= WALK_SCAN;
            pos_reg <= '0;
            request_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            pos_reg <= pos_next;
            request_reg <= (state_next == WALK_OFFER);
        end
    end

    assign slot_index = pos_reg;
    assign slot_request = request_reg;
endmodule
`default_nettype wire

// [core/descriptor_list_map_registers.sv]
// APB register bank for descriptor list skip, final and completion maps
//
// Chosen here: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module descriptor_list_map_registers (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [list_map_pkg::ADDR_W-1:0] paddr,
    input wire logic [list_map_pkg::DATA_W-1:0] pwdata,
    output logic [list_map_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic [list_map_pkg::LIST_COUNT-1:0] slot_request,
    output logic [list_map_pkg::LIST_COUNT-1:0][list_map_pkg::IDX_W-1:0] slot_index,
    input wire logic [list_map_pkg::LIST_COUNT-1:0] slot_ack,
    input wire logic [list_map_pkg::LIST_COUNT-1:0] slot_follow,
    input wire logic [list_map_pkg::LIST_COUNT-1:0][list_map_pkg::IDX_W-1:0] slot_next_ptr,
    input wire logic [list_map_pkg::LIST_COUNT-1:0] done_pulse,
    input wire logic [list_map_pkg::LIST_COUNT-1:0][list_map_pkg::IDX_W-1:0] done_index
);
    import list_map_pkg::*;

    logic [LIST_COUNT-1:0][DATA_W-1:0] skip_reg;
    logic [LIST_COUNT-1:0][DATA_W-1:0] final_reg;
    logic [LIST_COUNT-1:0][DATA_W-1:0] done_bits;
    logic [LIST_COUNT-1:0] clear_strobe;
    logic [LIST_COUNT-1:0] status_reg;
    logic [LIST_COUNT-1:0] mask_reg;
    logic [LIST_COUNT-1:0] status_clear;
    logic [DATA_W-1:0] prdata_reg;
    logic [DATA_W-1:0] rd_data;
    logic pready_reg;
    logic pslverr_reg;
    logic irq_reg;
    logic rd_hit;
    logic setup_phase;
    logic access_done;
    logic wr_take;
    logic rd_take;

    function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [11:0] off);
        addr_is = (a == off);
    endfunction

    // Setup cycle prepares the answer, so the access phase never waits
    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && pready_reg;
    assign wr_take = access_done && pwrite && !pslverr_reg;
    assign rd_take = access_done && !pwrite && !pslverr_reg;

    always_comb begin
        rd_data = '0;
        rd_hit = 1'b0;
        for (int l = 0; l < LIST_COUNT; l++) begin
            if (addr_is(paddr, DONE_OFF[l])) begin
                rd_data = done_bits[l];
                rd_hit = 1'b1;
            end
            if (addr_is(paddr, SKIP_OFF[l])) begin
                rd_data = skip_reg[l];
                rd_hit = 1'b1;
            end
            if (addr_is(paddr, FINAL_OFF[l])) begin
                rd_data = final_reg[l];
                rd_hit = 1'b1;
            end
        end
        if (addr_is(paddr, EVENT_STATUS_OFF)) begin
            rd_data = {{(DATA_W-LIST_COUNT){1'b0}}, status_reg};
            rd_hit = 1'b1;
        end
        if (addr_is(paddr, EVENT_MASK_OFF)) begin
            rd_data = {{(DATA_W-LIST_COUNT){1'b0}}, mask_reg};
            rd_hit = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end else begin
            pready_reg <= setup_phase;
            // Unmapped or unaligned address answers with an error
            pslverr_reg <= setup_phase && !rd_hit;
            if (setup_phase && !pwrite) begin
                prdata_reg <= rd_data;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int l = 0; l < LIST_COUNT; l++) begin
                skip_reg[l] <= SKIP_RESET;
            end
        end else if (wr_take) begin
            for (int l = 0; l < LIST_COUNT; l++) begin
                if (addr_is(paddr, SKIP_OFF[l])) begin
                    skip_reg[l] <= pwdata;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int l = 0; l < LIST_COUNT; l++) begin
                final_reg[l] <= FINAL_RESET;
            end
        end else if (wr_take) begin
            for (int l = 0; l < LIST_COUNT; l++) begin
                if (addr_is(paddr, FINAL_OFF[l])) begin
                    final_reg[l] <= pwdata;
                end
            end
        end
    end

    // Writes to done maps are accepted and have no effect
    always_comb begin
        for (int l = 0; l < LIST_COUNT; l++) begin
            clear_strobe[l] = rd_take && addr_is(paddr, DONE_OFF[l]);
        end
    end

    genvar g;
    generate
        for (g = 0; g < LIST_COUNT; g++) begin : list_gen
            // Clear mask is the value sampled at setup, so later arrivals survive
            completion_map #(
                .DEPTH(DESC_COUNT)
            ) done_map (
                .pclk(pclk),
                .presetn(presetn),
                .done_pulse(done_pulse[g]),
                .done_index(done_index[g]),
                .clear_strobe(clear_strobe[g]),
                .clear_mask(prdata_reg),
                .bits(done_bits[g])
            );

            list_walker #(
                .DEPTH(DESC_COUNT)
            ) walker (
                .pclk(pclk),
                .presetn(presetn),
                .skip_bits(skip_reg[g]),
                .final_bits(final_reg[g]),
                .slot_ack(slot_ack[g]),
                .slot_follow(slot_follow[g]),
                .slot_next_ptr(slot_next_ptr[g]),
                .slot_index(slot_index[g]),
                .slot_request(slot_request[g])
            );
        end
    endgenerate

    always_comb begin
        status_clear = '0;
        if (wr_take && addr_is(paddr, EVENT_STATUS_OFF)) begin
            status_clear = pwdata[LIST_COUNT-1:0];
        end
    end

    // Set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= EVENT_STATUS_RESET;
        end else begin
            status_reg <= (status_reg & ~status_clear) | done_pulse;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= EVENT_MASK_RESET;
        end else if (wr_take && addr_is(paddr, EVENT_MASK_OFF)) begin
            mask_reg <= pwdata[LIST_COUNT-1:0];
        end
    end

    // Interrupt lags status by one cycle to keep the pin on a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(status_reg & mask_reg);
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;
endmodule
`default_nettype wire

// [tb/list_map_asserts.sv]
// Port-level checker for the descriptor list map registers
`timescale 1ns/1ns
`default_nettype none
module list_map_checker
    import list_map_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [LIST_COUNT-1:0] slot_request,
    input wire logic [LIST_COUNT-1:0][IDX_W-1:0] slot_index,
    input wire logic [LIST_COUNT-1:0] slot_ack,
    input wire logic [LIST_COUNT-1:0] slot_follow
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    setup_ready_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
    ready_single_a: assert property (pready |=> !pready) else $error("ready held too long");
    ready_cause_a: assert property (pready |-> $past(psel && !penable)) else $error("ready without setup");
    err_gate_a: assert property (pslverr |-> pready) else $error("error outside access");
    err_data_a: assert property (pslverr && !pwrite |-> prdata == '0) else $error("refused read data");
    // Gap after an ack: the walker needs a scan cycle first
    ack_drop_a: assert property (slot_request[0] && slot_ack[0] |=> !slot_request[0])
        else $error("offer not dropped");
    offer_hold_a: assert property (slot_request[1] && !slot_ack[1] |=> !slot_request[1] || $stable(slot_index[1]))
        else $error("offer moved");
    wrap_zero_a: assert property (slot_request[2] && slot_ack[2] && !slot_follow[2] && slot_index[2] == 5'h1f
        |=> slot_index[2] == 5'h00) else $error("no wrap at end");
endmodule
bind descriptor_list_map_registers list_map_checker u_list_map_checker (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slot_request(slot_request), .slot_index(slot_index), .slot_ack(slot_ack), .slot_follow(slot_follow));
`default_nettype wire

// [tb/descriptor_list_map_registers_tb.sv]
// Self-checking bench for the descriptor list map registers
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin bad_count++; \
    $display("unexpected %s expected %h seen %h", n, e, s); end end
module descriptor_list_map_registers_tb;
    import list_map_pkg::*;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, e;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, prdata, q;
    logic pready, pslverr, irq;
    logic [LIST_COUNT-1:0] slot_request, slot_ack = '0, slot_follow = '0, done_pulse = '0;
    logic [LIST_COUNT-1:0][IDX_W-1:0] slot_index, slot_next_ptr = '0, done_index = '0;
    int bad_count = 0, comparisons = 0, cyc = 0;
    descriptor_list_map_registers u_descriptor_list_map_registers (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .slot_request(slot_request), .slot_index(slot_index),
        .slot_ack(slot_ack), .slot_follow(slot_follow), .slot_next_ptr(slot_next_ptr),
        .done_pulse(done_pulse), .done_index(done_index));
    initial forever #2 pclk = ~pclk;
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Cycle ceiling, so a hang still reaches the closing report
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            conclude();
        end
    end
    task automatic do_reset();
        presetn <= 1'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
    endtask
    task automatic xf(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        // A completion raised for the setup edge lasts that one cycle
        done_pulse <= '0;
        do @(posedge pclk); while (pready !== 1'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        xf(1'h1, a, d);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
        xf(1'h0, a, '0);
        `CHK("read data", x, q)
    endtask
    task automatic pulse(input int l, input logic [IDX_W-1:0] i);
        done_index[l] <= i;
        done_pulse[l] <= 1'h1;
        @(posedge pclk);
        done_pulse[l] <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic offer(input int l, input logic [IDX_W-1:0] x, input logic f, input logic [IDX_W-1:0] p);
        int n;
        n = 0;
        while (slot_request[l] !== 1'h1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        `CHK("offer", {1'h1, x}, {slot_request[l], slot_index[l]})
        slot_follow[l] <= f;
        slot_next_ptr[l] <= p;
        slot_ack[l] <= 1'h1;
        @(posedge pclk);
        slot_ack[l] <= 1'h0;
        @(posedge pclk);
    endtask
    initial begin
        do_reset();
        `CHK("irq", 1'h0, irq)
        for (int l = 0; l < LIST_COUNT; l++) begin
            rd(SKIP_OFF[l], SKIP_RESET);
            rd(FINAL_OFF[l], FINAL_RESET);
            rd(DONE_OFF[l], DONE_RESET);
            wr(SKIP_OFF[l], 32'ha5c30f00 + l);
            rd(SKIP_OFF[l], 32'ha5c30f00 + l);
            wr(FINAL_OFF[l], 32'h80000000 >> l);
            rd(FINAL_OFF[l], 32'h80000000 >> l);
            pulse(l, 5'h1f);
            pulse(l, 5'h00);
            wr(DONE_OFF[l], 32'hffffffff);
            rd(DONE_OFF[l], 32'h80000001);
            rd(DONE_OFF[l], 32'h00000000);
            // Completion lands on the setup edge of a read
            done_index[l] <= 5'h03;
            done_pulse[l] <= 1'h1;
            rd(DONE_OFF[l], 32'h00000000);
            rd(DONE_OFF[l], 32'h00000008);
        end
        xf(1'h1, 12'h15c, 32'h00000000);
        `CHK("error", 1'h1, e)
        xf(1'h0, 12'h142, 32'h00000000);
        `CHK("error", 1'h1, e)
        rd(SKIP_OFF[2], 32'ha5c30f02);
        rd(EVENT_STATUS_OFF, 32'h00000007);
        wr(EVENT_MASK_OFF, 32'h00000002);
        rd(EVENT_MASK_OFF, 32'h00000002);
        `CHK("irq", 1'h1, irq)
        wr(EVENT_STATUS_OFF, 32'h00000002);
        rd(EVENT_STATUS_OFF, 32'h00000005);
        `CHK("irq", 1'h0, irq)
        // Mid-run reset gives every walker a known start
        do_reset();
        wr(FINAL_OFF[0], 32'h00000004);
        wr(SKIP_OFF[0], 32'hfffffffa);
        wr(FINAL_OFF[1], 32'h00000008);
        wr(SKIP_OFF[1], 32'hfffffff0);
        wr(SKIP_OFF[2], 32'h7ffffffe);
        offer(0, 5'h00, 1'h0, 5'h00);
        offer(0, 5'h02, 1'h0, 5'h00);
        offer(0, 5'h00, 1'h0, 5'h00);
        offer(1, 5'h00, 1'h1, 5'h02);
        offer(1, 5'h02, 1'h0, 5'h00);
        offer(1, 5'h03, 1'h1, 5'h01);
        offer(1, 5'h00, 1'h0, 5'h00);
        // Free-running scan reaches position 31 before it wraps to 0
        offer(2, 5'h1f, 1'h0, 5'h00);
        offer(2, 5'h00, 1'h0, 5'h00);
        offer(2, 5'h1f, 1'h0, 5'h00);
        conclude();
    end
endmodule
`default_nettype wire
